// ---- rtl/ascp_consts.svh ----
// constants of the serial command port: addresses, command codes, field positions, reset values
`ifndef ASCP_CONSTS_SVH
`define ASCP_CONSTS_SVH

// configuration register addresses
`define ASCP_ADDR_INPUT_GAIN 2'h0
`define ASCP_ADDR_RATE_MODE 2'h1
`define ASCP_ADDR_REF_CURRENT 2'h2
`define ASCP_ADDR_ROUTE_READY 2'h3
`define ASCP_NUM_REGS 4
`define ASCP_CFG_RESET 8'h00

// ready-on-output select sits in the route/ready register
`define ASCP_RDY_SEL_BIT 1

// command byte codes; the low bits are don't-care or operands
`define ASCP_CMD_SLEEP_HI 7'h01
`define ASCP_CMD_START_HI 7'h04
`define ASCP_CMD_RDATA_HI 4'h1
`define ASCP_CMD_REG_READ_CMD_HI 4'h2
`define ASCP_CMD_REG_WRITE_CMD_HI 4'h4

// result word: two bytes, then eight low and endless high padding bits
`define ASCP_RES_LAST_BYTE 2'h1
`define ASCP_PAD_LOW 8'h00
`define ASCP_PAD_HIGH 8'hFF
`define ASCP_LAST_BIT 3'h7

// synchroniser reset levels: chip select idles high, toggles idle low
`define ASCP_SYNC_BITS 5
`define ASCP_SYNC_INIT 5'h01

`endif

// ---- rtl/ascp_pkg.sv ----
// types shared by the serial command port
package ascp_pkg;

  // serial engine state; decode -> read result -> decode and decode -> write change one bit, register read two
  typedef enum logic [1:0] {
    ASCP_DECODE = 2'b00,
    ASCP_READ_RESULT = 2'b01,
    ASCP_READ_REGS = 2'b11,
    ASCP_WRITE_REGS = 2'b10
  } ascp_state_t;

  // what the output shifter loads after a read-type command byte
  typedef enum logic {
    ASCP_LOAD_RESULT = 1'b0,
    ASCP_LOAD_REGS = 1'b1
  } ascp_load_t;

endpackage

// ---- rtl/ascp_port.sv ----
// serial command port: command decode, result and register readout, config registers
//
// Operation
// - sleep command turns analog, low-side switch and currents off; registers kept
// - sleep requested during a conversion waits until that conversion ends
// - start command after sleep returns analog parts to their earlier state
// - read-result command loads the output shifter with the newest stored result
// - result arriving during read-result byte: old one loaded, new one waits and drives ready low once chip select is high
// - register read shifts out all four registers from start address; decode resumes after count plus one bytes
// - register write takes count plus one host bytes into consecutive registers
// - written values commit on the final falling serial clock edge of the write
// - new result drives ready pin low, and shared output low when selected
// - results go out msb first, two bytes, changing on rising serial clock
// - during a plain data read, input bytes are decoded at each byte boundary
// - read command during plain read aborts it, except during the final byte
// - requested data appear at first rising edge after the command byte
// - write during a read leaves the read intact, then restarts the filter
// - commands ignored while a read command runs; host reads everything first
// - chip select high floats the shared output; ready pin stays driven
// - chip select low with ready select set drives shared output ready level at once
// - after a result, eight low then further high bits return the shared output high
// - after read-result the ready pin shows whether a newer result exists
// - four byte registers, serial access only, clear on reset, kept in sleep
// - two-bit start address selects a register, two-bit count is bytes minus one
// - input sampled on falling edges; ready returns high after next rising edge
// - chip select high resets the serial engine and discards partial commands
`include "ascp_consts.svh"

module ascp_port (
  // system clock domain
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // converter side
  input wire logic conv_busy,
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  output logic analog_sleep,
  output logic low_side_switch_open,
  output logic excitation_current_off,
  output logic conv_start,
  output logic filter_restart,
  // configuration seen by the analog path
  output logic [7:0] input_gain_config,
  output logic [7:0] rate_mode_config,
  output logic [7:0] reference_current_config,
  output logic [7:0] current_route_ready_config,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic shared_serial_out,
  output logic shared_serial_out_oe,
  output logic conv_done_n
);

  // ---------------------------------------------------------------- link side
  // chip select high clears the frame state at once
  logic frame_rst;
  assign frame_rst = reset | cs_n;

  ascp_pkg::ascp_state_t state_reg;
  ascp_pkg::ascp_load_t ld_kind_reg;
  logic [6:0] rx_sr_reg;
  logic [2:0] fbit_reg;
  logic [1:0] addr_reg;
  logic [1:0] left_reg;
  logic [1:0] widx_reg;
  logic ld_tgl_reg;
  logic sleep_tgl_reg;
  logic start_tgl_reg;
  logic wr_tgl_reg;
  logic [31:0] cfg_bus;
  logic [15:0] pub_data_reg;
  logic conv_done_n_reg;

  // byte assembly and command decode
  wire byte_done = (fbit_reg == `ASCP_LAST_BIT);
  wire [7:0] rx_byte = {rx_sr_reg, din};
  wire in_decode = (state_reg == ascp_pkg::ASCP_DECODE);
  wire is_sleep = (rx_byte[7:1] == `ASCP_CMD_SLEEP_HI);
  wire is_start = (rx_byte[7:1] == `ASCP_CMD_START_HI);
  wire is_rdata = (rx_byte[7:4] == `ASCP_CMD_RDATA_HI);
  wire is_reg_read_cmd = (rx_byte[7:4] == `ASCP_CMD_REG_READ_CMD_HI);
  wire is_reg_write_cmd = (rx_byte[7:4] == `ASCP_CMD_REG_WRITE_CMD_HI);
  wire dec_now = byte_done & in_decode;
  wire last_byte = byte_done & (left_reg == 2'h0);
  wire in_write = (state_reg == ascp_pkg::ASCP_WRITE_REGS);
  wire wr_last = in_write & last_byte;
  // target of the byte being written; past the top register it is dropped
  wire [2:0] wr_target = {1'b0, addr_reg} + {1'b0, widx_reg};

  // falling edge: sample input, step the command engine
  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      rx_sr_reg <= 7'h00;
      fbit_reg <= 3'h0;
      state_reg <= ascp_pkg::ASCP_DECODE;
      ld_kind_reg <= ascp_pkg::ASCP_LOAD_RESULT;
      ld_tgl_reg <= 1'b0;
      addr_reg <= 2'h0;
      left_reg <= 2'h0;
      widx_reg <= 2'h0;
    end else begin
      rx_sr_reg <= rx_byte[6:0];
      fbit_reg <= fbit_reg + 3'h1;
      if (dec_now && is_rdata) begin
        state_reg <= ascp_pkg::ASCP_READ_RESULT;
        ld_kind_reg <= ascp_pkg::ASCP_LOAD_RESULT;
        ld_tgl_reg <= ~ld_tgl_reg;
        left_reg <= `ASCP_RES_LAST_BYTE;
      end else if (dec_now && is_reg_read_cmd) begin
        state_reg <= ascp_pkg::ASCP_READ_REGS;
        ld_kind_reg <= ascp_pkg::ASCP_LOAD_REGS;
        ld_tgl_reg <= ~ld_tgl_reg;
        addr_reg <= rx_byte[3:2];
        left_reg <= rx_byte[1:0];
      end else if (dec_now && is_reg_write_cmd) begin
        state_reg <= ascp_pkg::ASCP_WRITE_REGS;
        addr_reg <= rx_byte[3:2];
        left_reg <= rx_byte[1:0];
        widx_reg <= 2'h0;
      end else if (byte_done && !in_decode) begin
        // reads ignore input until every byte is out
        if (left_reg == 2'h0) begin
          state_reg <= ascp_pkg::ASCP_DECODE;
        end else begin
          left_reg <= left_reg - 2'h1;
        end
        widx_reg <= widx_reg + 2'h1;
      end
    end
  end

  // event toggles survive chip select so the system side never misses one
  always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
      sleep_tgl_reg <= 1'b0;
      start_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
    end else begin
      if (dec_now && is_sleep) begin
        sleep_tgl_reg <= ~sleep_tgl_reg;
      end
      if (dec_now && is_start) begin
        start_tgl_reg <= ~start_tgl_reg;
      end
      if (wr_last) begin
        wr_tgl_reg <= ~wr_tgl_reg;
      end
      // any other byte value falls through untouched
    end
  end

  // per register: staging of early write bytes and the register itself
  genvar gi;
  generate
    for (gi = 0; gi < `ASCP_NUM_REGS; gi = gi + 1) begin : g_cfg
      logic [7:0] stage_reg;
      logic staged_reg;
      logic [7:0] cfg_reg;
      wire hit = (wr_target == 3'(gi));

      // bytes before the last are held until the write completes
      always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
          stage_reg <= `ASCP_CFG_RESET;
          staged_reg <= 1'b0;
        end else if (in_write && byte_done && hit && !last_byte) begin
          stage_reg <= rx_byte;
          staged_reg <= 1'b1;
        end
      end

      // registers clear only on reset, never on chip select or sleep
      always_ff @(negedge sclk or posedge reset) begin
        if (reset) begin
          cfg_reg <= `ASCP_CFG_RESET;
        end else if (wr_last && hit) begin
          cfg_reg <= rx_byte;
        end else if (wr_last && staged_reg) begin
          cfg_reg <= stage_reg;
        end
      end

      assign cfg_bus[31 - 8 * gi -: 8] = cfg_reg;
    end
  endgenerate

  wire [7:0] route_ready_reg = cfg_bus[7:0];
  wire ready_sel = route_ready_reg[`ASCP_RDY_SEL_BIT];

  // register readout wraps from the top register back to the first
  wire [63:0] cfg_twice = {cfg_bus, cfg_bus};
  wire [5:0] rd_shift = {1'b0, addr_reg, 3'h0};
  wire [63:0] cfg_rot = cfg_twice << rd_shift;
  wire [31:0] reg_word = cfg_rot[63:32];

  logic started_reg;
  logic seen_ld_reg;
  logic [15:0] snap_reg;
  logic [31:0] tx_sr_reg;
  logic sso_reg;
  logic rd_tgl_reg;

  // load images: result then eight low then high padding bits
  wire [31:0] first_word = {pub_data_reg, `ASCP_PAD_LOW, `ASCP_PAD_HIGH};
  wire [31:0] rdata_word = {snap_reg, `ASCP_PAD_LOW, `ASCP_PAD_HIGH};
  wire ld_pend = (ld_tgl_reg != seen_ld_reg);
  wire [31:0] ld_word = (ld_kind_reg == ascp_pkg::ASCP_LOAD_REGS) ? reg_word : rdata_word;

  // rising edge: shift out msb first; the system side freezes the published
  // result while chip select is low, so it is steady at the first edge
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      started_reg <= 1'b0;
      seen_ld_reg <= 1'b0;
      snap_reg <= 16'h0000;
      tx_sr_reg <= 32'hFFFFFFFF;
      sso_reg <= 1'b1;
    end else if (!started_reg) begin
      started_reg <= 1'b1;
      snap_reg <= pub_data_reg;
      sso_reg <= first_word[31];
      tx_sr_reg <= {first_word[30:0], 1'b1};
    end else if (ld_pend) begin
      seen_ld_reg <= ld_tgl_reg;
      sso_reg <= ld_word[31];
      tx_sr_reg <= {ld_word[30:0], 1'b1};
    end else begin
      sso_reg <= tx_sr_reg[31]; // a write leaves the shift untouched
      tx_sr_reg <= {tx_sr_reg[30:0], 1'b1};
    end
  end

  // the first rising edge of a frame starts a read of the stored result
  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      rd_tgl_reg <= 1'b0;
    end else if (!cs_n && !started_reg) begin
      rd_tgl_reg <= ~rd_tgl_reg;
    end
  end

  // shared output: floats with chip select high, ready level if selected (else high) before the first
  // edge, shifted data after it
  wire idle_level = ~ready_sel | conv_done_n_reg;
  assign shared_serial_out = started_reg ? sso_reg : idle_level;
  assign shared_serial_out_oe = ~cs_n;

  // -------------------------------------------------------------- system side
  // three-stage synchronisers; a change counts when stages two and three agree
  wire [`ASCP_SYNC_BITS-1:0] async_in = {rd_tgl_reg, wr_tgl_reg, start_tgl_reg, sleep_tgl_reg, cs_n};
  localparam logic [`ASCP_SYNC_BITS-1:0] sync_init = `ASCP_SYNC_INIT;
  logic [`ASCP_SYNC_BITS-1:0] acc;
  logic [`ASCP_SYNC_BITS-1:0] chg;

  generate
    for (gi = 0; gi < `ASCP_SYNC_BITS; gi = gi + 1) begin : g_sync
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic acc_reg;
      wire agree = (s2_reg == s3_reg);

      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          s1_reg <= sync_init[gi];
          s2_reg <= sync_init[gi];
          s3_reg <= sync_init[gi];
          acc_reg <= sync_init[gi];
        end else if (clk_en) begin
          s1_reg <= async_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (agree) begin
            acc_reg <= s3_reg;
          end
        end
      end

      assign acc[gi] = acc_reg;
      assign chg[gi] = agree & (s3_reg != acc_reg);
    end
  endgenerate

  wire cs_idle = acc[0];
  wire sleep_ev = chg[1];
  wire start_ev = chg[2];
  wire wr_ev = chg[3];
  wire rd_ev = chg[4];

  logic [15:0] pend_data_reg;
  logic pending_reg;
  logic sleep_req_reg;
  logic asleep_reg;
  logic conv_start_reg;
  logic filter_restart_reg;
  logic [31:0] cfg_out_reg;

  // a result is published only while the link is idle; one arriving mid
  // frame waits, so a read in that frame gets the older one
  wire take_now = result_valid & cs_idle;
  wire flush_pend = pending_reg & cs_idle & ~result_valid;
  wire publish = take_now | flush_pend;

  // result buffer and pending slot
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pub_data_reg <= 16'h0000;
      pend_data_reg <= 16'h0000;
      pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (take_now) begin
        pub_data_reg <= result_data;
        pending_reg <= 1'b0;
      end else if (flush_pend) begin
        pub_data_reg <= pend_data_reg;
        pending_reg <= 1'b0;
      end else if (result_valid) begin
        pend_data_reg <= result_data;
        pending_reg <= 1'b1;
      end
    end
  end

  // ready pin: falls on a new result, rises once a read starts unless a newer
  // result is waiting; a publish wins over a read event
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_done_n_reg <= 1'b1;
    end else if (clk_en) begin
      if (publish) begin
        conv_done_n_reg <= 1'b0;
      end else if (rd_ev && !pending_reg) begin
        conv_done_n_reg <= 1'b1;
      end
    end
  end

  // power state: sleep waits for the running conversion; start or a register
  // write wakes, and the analog settings come back from the kept registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_req_reg <= 1'b0;
      asleep_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_ev || wr_ev) begin
        sleep_req_reg <= 1'b0;
        asleep_reg <= 1'b0;
      end else if (sleep_ev) begin
        sleep_req_reg <= 1'b1;
      end else if (sleep_req_reg && !conv_busy) begin
        sleep_req_reg <= 1'b0;
        asleep_reg <= 1'b1;
      end
    end
  end

  // command pulses and the configuration copy for the analog path; the copy
  // is taken only after a completed write, when the link words are steady
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      conv_start_reg <= 1'b0;
      filter_restart_reg <= 1'b0;
      cfg_out_reg <= {4{`ASCP_CFG_RESET}};
    end else if (clk_en) begin
      conv_start_reg <= start_ev;
      filter_restart_reg <= wr_ev;
      if (wr_ev) begin
        cfg_out_reg <= cfg_bus;
      end
    end
  end

  // outputs
  assign analog_sleep = asleep_reg;
  assign low_side_switch_open = asleep_reg;
  assign excitation_current_off = asleep_reg;
  assign conv_start = conv_start_reg;
  assign filter_restart = filter_restart_reg;
  assign conv_done_n = conv_done_n_reg;
  assign input_gain_config = cfg_out_reg[31:24];
  assign rate_mode_config = cfg_out_reg[23:16];
  assign reference_current_config = cfg_out_reg[15:8];
  assign current_route_ready_config = cfg_out_reg[7:0];

endmodule

// ---- verif/ascp_port_props.sv ----
// concurrent checks on the ports of the serial command port
module ascp_port_props (
  // system clock domain
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // converter side
  input wire logic conv_busy,
  input wire logic result_valid,
  input wire logic analog_sleep,
  input wire logic low_side_switch_open,
  input wire logic excitation_current_off,
  input wire logic conv_start,
  input wire logic filter_restart,
  // configuration
  input wire logic [7:0] input_gain_config,
  input wire logic [7:0] rate_mode_config,
  input wire logic [7:0] reference_current_config,
  input wire logic [7:0] current_route_ready_config,
  // serial link
  input wire logic cs_n,
  input wire logic shared_serial_out_oe,
  input wire logic conv_done_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] since_restart;
  wire [31:0] cfg_all;
  assign cfg_all = {input_gain_config, rate_mode_config, reference_current_config, current_route_ready_config};
  // cycles since the last restart pulse, saturating; config outputs may trail the pulse slightly
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_restart <= 3'h7;
    end else if (filter_restart) begin
      since_restart <= 3'h0;
    end else if (since_restart != 3'h7) begin
      since_restart <= since_restart + 3'h1;
    end
  end
  // result taken while chip select has been high long enough for the synchroniser
  sequence s_publish;
    result_valid && clk_en && cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) && $past(cs_n, 5);
  endsequence
  sequence s_restart_done;
    ##1 !filter_restart ##[0:3] !analog_sleep;
  endsequence
  sequence s_start_done;
    ##1 !conv_start ##[0:3] !analog_sleep;
  endsequence
  a_oe_follows_cs: assert property (@(posedge clk) disable iff (reset) shared_serial_out_oe == !cs_n)
    else $error("shared output enable differs from chip select");
  a_sleep_outputs_tied: assert property (@(posedge clk) disable iff (reset)
    analog_sleep == low_side_switch_open && analog_sleep == excitation_current_off)
    else $error("sleep outputs disagree");
  a_sleep_waits_busy: assert property (@(posedge clk) disable iff (reset) $rose(analog_sleep) |-> !$past(conv_busy))
    else $error("sleep entered during a conversion");
  a_publish_ready_low: assert property (@(posedge clk) disable iff (reset) s_publish |-> ##[1:3] !conv_done_n)
    else $error("ready pin did not fall after a new result");
  a_ready_rise_frame: assert property (@(posedge clk) disable iff (reset) $rose(conv_done_n) |-> $past(!cs_n, 2))
    else $error("ready pin rose outside a frame");
  a_restart_clears_sleep: assert property (@(posedge clk) disable iff (reset) filter_restart |-> s_restart_done)
    else $error("restart pulse too long or sleep kept");
  a_start_wakes_up: assert property (@(posedge clk) disable iff (reset) conv_start |-> s_start_done)
    else $error("start pulse too long or sleep kept");
  a_config_by_write: assert property (@(posedge clk) disable iff (reset)
    $changed(cfg_all) |-> (since_restart <= 3'h4) or (##[0:4] filter_restart))
    else $error("configuration changed without a write");
endmodule

bind ascp_port ascp_port_props u_props (.clk(clk), .reset(reset), .clk_en(clk_en), .conv_busy(conv_busy),
  .result_valid(result_valid), .analog_sleep(analog_sleep), .low_side_switch_open(low_side_switch_open),
  .excitation_current_off(excitation_current_off), .conv_start(conv_start), .filter_restart(filter_restart),
  .input_gain_config(input_gain_config), .rate_mode_config(rate_mode_config),
  .reference_current_config(reference_current_config), .current_route_ready_config(current_route_ready_config),
  .cs_n(cs_n), .shared_serial_out_oe(shared_serial_out_oe), .conv_done_n(conv_done_n));

// ---- verif/ascp_host.sv ----
// host controller model: spi mode 1 frames with a 64 ns link clock
module ascp_host (
  // serial link
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip;
  wire line;
  // a released output shows a changing level so a float never passes for data
  assign line = so_oe ? so : flip;
  initial begin
    sclk = 1'b0; // link clock stands still outside frames
    cs_n = 1'b1;
    din = 1'b0;
    flip = 1'b0;
  end
  // one frame: level seen just after select, then whole bytes msb first
  task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$], output logic lvl);
    logic [7:0] b;
    rx = {};
    cs_n = 1'b0;
    #5;
    lvl = line;
    #95; // lead time lets the result buffer freeze before the first edge
    foreach (tx[k]) begin
      for (int i = 7; i >= 0; i--) begin
        sclk = 1'b1;
        din = tx[k][i];
        #32;
        b[i] = line;
        sclk = 1'b0;
        flip = ~flip;
        #32;
      end
      rx.push_back(b);
    end
    #32;
    cs_n = 1'b1;
    din = ~din;
    #200;
  endtask
endmodule

// ---- verif/ascp_port_tb.sv ----
// self-checking bench for the serial command port
`define ASCP_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module ascp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, clk_en, conv_busy, result_valid;
  logic [15:0] result_data;
  logic analog_sleep, low_side_switch_open, excitation_current_off, conv_start, filter_restart;
  logic [7:0] input_gain_config, rate_mode_config, reference_current_config, current_route_ready_config;
  logic sclk, cs_n, din, shared_serial_out, shared_serial_out_oe, conv_done_n, lvl;
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  logic [7:0] restart_cnt = 8'h00;
  logic [7:0] start_cnt = 8'h00;
  int fail_count = 0;
  int checks_done = 0;
  wire [31:0] cfg;
  assign cfg = {input_gain_config, rate_mode_config, reference_current_config, current_route_ready_config};

  ascp_port dut (.clk(clk), .reset(reset), .clk_en(clk_en), .conv_busy(conv_busy), .result_valid(result_valid),
    .result_data(result_data), .analog_sleep(analog_sleep), .low_side_switch_open(low_side_switch_open),
    .excitation_current_off(excitation_current_off), .conv_start(conv_start), .filter_restart(filter_restart),
    .input_gain_config(input_gain_config), .rate_mode_config(rate_mode_config),
    .reference_current_config(reference_current_config), .current_route_ready_config(current_route_ready_config),
    .sclk(sclk), .cs_n(cs_n), .din(din), .shared_serial_out(shared_serial_out),
    .shared_serial_out_oe(shared_serial_out_oe), .conv_done_n(conv_done_n));
  ascp_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .so(shared_serial_out), .so_oe(shared_serial_out_oe));

  always #10 clk = ~clk;
  // pulse counters, since pulses are too short to catch from the sequence
  always @(posedge clk) begin
    if (filter_restart === 1'b1) restart_cnt <= restart_cnt + 8'h01;
    if (conv_start === 1'b1) start_cnt <= start_cnt + 8'h01;
  end

  task automatic wrap_up();
    if (fail_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic publish(input logic [15:0] value);
    @(negedge clk);
    result_data = value;
    result_valid = 1'b1;
    @(negedge clk);
    result_valid = 1'b0;
  endtask

  initial begin
    #1000000;
    fail_count++;
    wrap_up();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    clk_en = 1'b1;
    conv_busy = 1'b0;
    result_valid = 1'b0;
    result_data = 16'h0000;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    repeat (6) @(negedge clk);
    `ASCP_CHK(cfg, 32'h00000000);
    `ASCP_CHK({conv_done_n, analog_sleep, shared_serial_out_oe}, 3'b100);
    // clock enable low freezes the result side, so this pulse is lost
    clk_en = 1'b0;
    publish(16'hBEEF);
    repeat (3) @(negedge clk);
    `ASCP_CHK(conv_done_n, 1'b1);
    clk_en = 1'b1;
    // write all four registers, ready on output selected
    tx = {8'h43, 8'h11, 8'h22, 8'h33, 8'hA2};
    host.xfer(tx, rx, lvl);
    repeat (8) @(negedge clk);
    `ASCP_CHK(cfg, 32'h112233A2);
    `ASCP_CHK(restart_cnt, 8'h01);
    // read three from the top address with wrap; commands in the data slots are ignored
    tx = {8'h2E, 8'h10, 8'h20, 8'h40, 8'h00};
    host.xfer(tx, rx, lvl);
    `ASCP_CHK({rx[1], rx[2], rx[3], rx[4]}, 32'hA2112233);
    // incomplete write, then unknown bytes: nothing changes
    tx = {8'h41, 8'h99};
    host.xfer(tx, rx, lvl);
    tx = {8'h30, 8'h80, 8'hF0, 8'h0C};
    host.xfer(tx, rx, lvl);
    repeat (8) @(negedge clk);
    `ASCP_CHK({cfg, restart_cnt, start_cnt}, 48'h112233A20100);
    // direct read with a write sent alongside, then the sixteen padding clocks
    publish(16'hA5C3);
    repeat (3) @(negedge clk);
    `ASCP_CHK(conv_done_n, 1'b0);
    tx = {8'h40, 8'h5A, 8'h00, 8'h00};
    host.xfer(tx, rx, lvl);
    `ASCP_CHK(lvl, 1'b0);
    `ASCP_CHK({rx[0], rx[1], rx[2], rx[3]}, 32'hA5C300FF);
    `ASCP_CHK({conv_done_n, shared_serial_out_oe}, 2'b10);
    `ASCP_CHK({input_gain_config, restart_cnt}, 16'h5A02);
    tx = {};
    host.xfer(tx, rx, lvl);
    `ASCP_CHK(lvl, 1'b1);
    // read-result command with the newest result
    publish(16'h1234);
    tx = {8'h10, 8'h00, 8'h00};
    host.xfer(tx, rx, lvl);
    `ASCP_CHK({rx[1], rx[2], conv_done_n}, 17'h02469);
    // result arrives in the command byte: older data read, ready falls once the frame ends
    fork
      host.xfer(tx, rx, lvl);
      begin
        repeat (10) @(negedge clk);
        publish(16'h5555);
      end
    join
    repeat (4) @(negedge clk);
    `ASCP_CHK({rx[1], rx[2], conv_done_n}, 17'h02468);
    tx = {8'h00, 8'h00};
    host.xfer(tx, rx, lvl);
    `ASCP_CHK({rx[0], rx[1]}, 16'h5555);
    // sleep waits for the running conversion, keeps registers, start wakes up
    @(negedge clk);
    conv_busy = 1'b1;
    tx = {8'h02};
    host.xfer(tx, rx, lvl);
    repeat (10) @(negedge clk);
    `ASCP_CHK(analog_sleep, 1'b0);
    conv_busy = 1'b0;
    for (int i = 0; i < 50 && analog_sleep !== 1'b1; i++) @(negedge clk);
    if (analog_sleep !== 1'b1) begin
      fail_count++;
      wrap_up();
    end
    `ASCP_CHK({analog_sleep, low_side_switch_open, excitation_current_off}, 3'b111);
    tx = {8'h20, 8'h00};
    host.xfer(tx, rx, lvl);
    `ASCP_CHK({rx[1], cfg}, 40'h5A5A2233A2);
    tx = {8'h08};
    host.xfer(tx, rx, lvl);
    repeat (4) @(negedge clk);
    `ASCP_CHK({start_cnt, analog_sleep}, 9'h002);
    wrap_up();
  end
endmodule
